// >>> inc/sdle_pkg.sv
// package: constants and types for the serial diagnostic loopback/echo switch
package sdle_pkg;

  // ****************************************************************
  // misc_control_reg field positions and reset value
  // ****************************************************************
  localparam int unsigned      MISC_WIDTH     = 8;
  localparam int unsigned      MISC_LOOP_BIT  = 4;
  localparam int unsigned      MISC_ECHO_BIT  = 3;
  localparam logic [7:0]       MISC_RESET_VAL = 8'h00;

  // ****************************************************************
  // clocking figures
  // ****************************************************************
  localparam int unsigned      SYS_CLK_MHZ     = 200;
  localparam int unsigned      RECOV_CLK_MHZ   = 32;
  localparam int unsigned      PERIPH_CLK_MHZ  = 16;
  localparam int unsigned      RECOV_DUTY_PCT  = 50;
  localparam int unsigned      FM_OVERSAMPLE   = 16;
  localparam int unsigned      FM_MAX_KBPS     = 2000;
  localparam int unsigned      SYNC_STAGES     = 2;

  // ****************************************************************
  // data path modes
  // ****************************************************************
  typedef enum logic [1:0] {
    SDLE_NORMAL = 2'b00,
    SDLE_LOOP   = 2'b01,
    SDLE_ECHO   = 2'b11,
    SDLE_BOTH   = 2'b10
  } sdle_mode_t;

endpackage : sdle_pkg

// >>> inc/sdle_sync_if.sv
// interface: pin samples handed from the synchroniser to the switch
interface sdle_sync_if;
  logic rx_data;
  logic carrier_detect;
  logic clear_to_send;
  logic rx_tx_clock;

  modport sync_side (output rx_data, output carrier_detect, output clear_to_send,
                     output rx_tx_clock);
  modport user_side (input rx_data, input carrier_detect, input clear_to_send,
                     input rx_tx_clock);
endinterface : sdle_sync_if

// >>> logic/sdle_pin_sync.sv
// module: two-stage synchroniser for the serial channel's asynchronous pins
module sdle_pin_sync #(
  parameter int unsigned STAGES = sdle_pkg::SYNC_STAGES
) (
  // clock and reset
  input  wire logic      i_clk_sys,
  input  wire logic      i_rst_b,
  // raw pins
  input  wire logic      i_rx_data,
  input  wire logic      i_carrier_detect,
  input  wire logic      i_clear_to_send,
  input  wire logic      i_rx_tx_clock,
  // synchronised samples
  sdle_sync_if.sync_side o_sync
);

  // a single flop would hand a possibly metastable sample straight to logic
  if (STAGES < 2) begin : g_stages_chk
    $error("sdle_pin_sync: STAGES must be at least 2");
  end

  logic [STAGES-1:0] rx_q;
  logic [STAGES-1:0] cd_q;
  logic [STAGES-1:0] cts_q;
  logic [STAGES-1:0] clk_q;

  // idle line is mark (high); modem inputs idle inactive (high, active low pins)
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      rx_q  <= '1;
      cd_q  <= '1;
      cts_q <= '1;
      clk_q <= '0;
    end else begin
      rx_q  <= {rx_q[STAGES-2:0], i_rx_data};
      cd_q  <= {cd_q[STAGES-2:0], i_carrier_detect};
      cts_q <= {cts_q[STAGES-2:0], i_clear_to_send};
      clk_q <= {clk_q[STAGES-2:0], i_rx_tx_clock};
    end
  end

  assign o_sync.rx_data        = rx_q[STAGES-1];
  assign o_sync.carrier_detect = cd_q[STAGES-1];
  assign o_sync.clear_to_send  = cts_q[STAGES-1];
  assign o_sync.rx_tx_clock    = clk_q[STAGES-1];

endmodule : sdle_pin_sync

// >>> logic/sdle_switch.sv
// module: loopback / auto echo data path switch of one serial channel

// Function
// - loopback bit D4 routes transmitter output to receiver; transmit pin still driven by transmitter.
// - in loopback, carrier detect and clear to send are not automatic enables.
// - clock recovery input always comes from the receive pin, never the receiver input.
// - echo bit D3 drives transmit pin from receive pin; receiver fed from receive pin.
// - in echo, clear to send ignored; transmitter output goes nowhere.
// - both bits set selects echo and ignores both automatic enables.
// - clock recovery runs from 32 MHz in FM sync and async modes, up to 2 mb/s.
module sdle_switch (
  // clock and reset
  input  wire logic                           i_clk_sys,
  input  wire logic                           i_rst_b,
  // control register write port
  input  wire logic                           i_misc_wr,
  input  wire logic [sdle_pkg::MISC_WIDTH-1:0] i_misc_wdata,
  // channel configuration
  input  wire logic                           i_auto_enables,
  // line pins
  input  wire logic                           i_rx_data_pin,
  input  wire logic                           i_carrier_detect_in_b,
  input  wire logic                           i_clear_to_send_in_b,
  input  wire logic                           i_rx_tx_clock_pin,
  output      logic                           o_tx_data_pin,
  // transmitter side
  input  wire logic                           i_tx_serial,
  input  wire logic                           i_tx_enable_sw,
  output      logic                           o_tx_enable,
  // receiver side
  input  wire logic                           i_rx_enable_sw,
  output      logic                           o_rx_serial,
  output      logic                           o_rx_enable,
  // clock recovery loop
  output      logic                           o_recov_data,
  output      logic                           o_recov_clock,
  // status
  output      logic [sdle_pkg::MISC_WIDTH-1:0] o_misc_control_reg,
  output      logic [1:0]                     o_mode
);

  // ****************************************************************
  // pin synchronisation
  // ****************************************************************
  // every pin, the clock pin included, goes through the two-flop chain
  sdle_sync_if sync_bus ();

  sdle_pin_sync #(
    .STAGES (sdle_pkg::SYNC_STAGES)
  ) u_sync (
    .i_clk_sys        (i_clk_sys),
    .i_rst_b          (i_rst_b),
    .i_rx_data        (i_rx_data_pin),
    .i_carrier_detect (i_carrier_detect_in_b),
    .i_clear_to_send  (i_clear_to_send_in_b),
    .i_rx_tx_clock    (i_rx_tx_clock_pin),
    .o_sync           (sync_bus.sync_side)
  );

  // ****************************************************************
  // elaboration checks
  // ****************************************************************
  // both mode bits must sit inside the stored register word
  if (sdle_pkg::MISC_LOOP_BIT >= sdle_pkg::MISC_WIDTH) begin : g_loop_bit_chk
    $error("sdle_switch: loopback bit lies outside the control register");
  end
  if (sdle_pkg::MISC_ECHO_BIT >= sdle_pkg::MISC_WIDTH) begin : g_echo_bit_chk
    $error("sdle_switch: echo bit lies outside the control register");
  end
  // distinct positions, or echo and loopback would alias each other
  if (sdle_pkg::MISC_LOOP_BIT == sdle_pkg::MISC_ECHO_BIT) begin : g_bits_chk
    $error("sdle_switch: loopback and echo bits share a position");
  end

  // ****************************************************************
  // control register
  // ****************************************************************
  logic [sdle_pkg::MISC_WIDTH-1:0] misc_control_reg;
  sdle_pkg::sdle_mode_t            mode;
  sdle_pkg::sdle_mode_t            next_mode;

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      misc_control_reg <= sdle_pkg::MISC_RESET_VAL;
    end else if (i_misc_wr) begin
      misc_control_reg <= i_misc_wdata;
    end
  end

  function automatic sdle_pkg::sdle_mode_t decode_mode(
    input logic loop_bit,
    input logic echo_bit
  );
    sdle_pkg::sdle_mode_t m;
    m = sdle_pkg::SDLE_NORMAL;
    case ({echo_bit, loop_bit})
      2'h0:    m = sdle_pkg::SDLE_NORMAL;
      2'h1:    m = sdle_pkg::SDLE_LOOP;
      2'h2:    m = sdle_pkg::SDLE_ECHO;
      2'h3:    m = sdle_pkg::SDLE_BOTH;
      default: m = sdle_pkg::SDLE_NORMAL;
    endcase
    return m;
  endfunction : decode_mode

  assign next_mode = decode_mode(misc_control_reg[sdle_pkg::MISC_LOOP_BIT],
                                 misc_control_reg[sdle_pkg::MISC_ECHO_BIT]);

  // registered so the path switch changes on a clean cycle boundary
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      mode <= sdle_pkg::SDLE_NORMAL;
    end else begin
      mode <= next_mode;
    end
  end

  // ****************************************************************
  // data path and enables
  // ****************************************************************
  logic next_tx_pin;
  logic next_rx_serial;
  logic next_tx_en;
  logic next_rx_en;
  logic cd_active;
  logic cts_active;

  assign cd_active  = !sync_bus.carrier_detect;
  assign cts_active = !sync_bus.clear_to_send;

  // a modem input gates the software enable only when automatic
  // enables are configured and the mode does not override them
  function automatic logic gate_enable(
    input logic sw_en,
    input logic auto_en,
    input logic modem_active
  );
    return sw_en && (!auto_en || modem_active);
  endfunction : gate_enable

  always_comb begin
    next_tx_pin    = i_tx_serial;
    next_rx_serial = sync_bus.rx_data;
    next_tx_en     = gate_enable(i_tx_enable_sw, i_auto_enables, cts_active);
    next_rx_en     = gate_enable(i_rx_enable_sw, i_auto_enables, cd_active);
    case (mode)
      sdle_pkg::SDLE_NORMAL: begin
        next_tx_pin    = i_tx_serial;
        next_rx_serial = sync_bus.rx_data;
      end
      sdle_pkg::SDLE_LOOP: begin
        // recovery data still comes from the pin, so the loop cannot lock here
        next_tx_pin    = i_tx_serial;
        next_rx_serial = i_tx_serial;
        next_tx_en     = i_tx_enable_sw;
        next_rx_en     = i_rx_enable_sw;
      end
      sdle_pkg::SDLE_ECHO: begin
        // transmitter output deliberately unused here
        next_tx_pin    = sync_bus.rx_data;
        next_rx_serial = sync_bus.rx_data;
        next_tx_en     = i_tx_enable_sw;
      end
      sdle_pkg::SDLE_BOTH: begin
        // echo wins; a diagnostic corner, not a normal operating mode
        next_tx_pin    = sync_bus.rx_data;
        next_rx_serial = sync_bus.rx_data;
        next_tx_en     = i_tx_enable_sw;
        next_rx_en     = i_rx_enable_sw;
      end
      default: begin
        next_tx_pin    = i_tx_serial;
        next_rx_serial = sync_bus.rx_data;
      end
    endcase
  end

  // both paths rest at mark in reset, so no false start bit appears
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_tx_data_pin <= 1'b1;
      o_rx_serial   <= 1'b1;
    end else begin
      o_tx_data_pin <= next_tx_pin;
      o_rx_serial   <= next_rx_serial;
    end
  end

  // enables reset low; with auto enables set they stay low while the sync chain flushes after reset
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_tx_enable <= 1'b0;
      o_rx_enable <= 1'b0;
    end else begin
      o_tx_enable <= next_tx_en;
      o_rx_enable <= next_rx_en;
    end
  end

  // ****************************************************************
  // clock recovery source
  // ****************************************************************
  // the pin is sampled, so a 32 MHz recovery clock is resolved at 200 MHz;
  // the loop itself sits outside this block and runs at sixteen per bit
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_recov_data  <= 1'b1;
      o_recov_clock <= 1'b0;
    end else begin
      o_recov_data  <= sync_bus.rx_data;
      o_recov_clock <= sync_bus.rx_tx_clock;
    end
  end

  assign o_misc_control_reg = misc_control_reg;
  assign o_mode             = mode;

endmodule : sdle_switch

// >>> test/sdle_switch_chk.sv
// checker: port-level properties of the loopback and auto echo switch
module sdle_switch_chk (
  // clock, reset, control
  input wire logic                            i_clk_sys,
  input wire logic                            i_rst_b,
  input wire logic                            i_misc_wr,
  input wire logic [sdle_pkg::MISC_WIDTH-1:0] i_misc_wdata,
  // pins and channel inputs
  input wire logic                            i_rx_data_pin,
  input wire logic                            i_rx_tx_clock_pin,
  input wire logic                            i_tx_serial,
  input wire logic                            i_tx_enable_sw,
  input wire logic                            i_rx_enable_sw,
  // outputs watched
  input wire logic                            o_tx_data_pin,
  input wire logic                            o_tx_enable,
  input wire logic                            o_rx_serial,
  input wire logic                            o_rx_enable,
  input wire logic                            o_recov_data,
  input wire logic                            o_recov_clock,
  input wire logic [sdle_pkg::MISC_WIDTH-1:0] o_misc_control_reg,
  input wire logic [1:0]                      o_mode
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // history helpers: pin checks wait out the synchroniser after reset
  // ****************************************************************
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);
  logic [2:0] up;
  logic [1:0] m1, m2;
  logic       st;
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) up <= 3'h0;
    else if (up != 3'h7) up <= up + 3'h1;
  end
  always_ff @(posedge i_clk_sys) begin
    m1 <= o_mode;
    m2 <= m1;
  end
  assign st = (up == 3'h7) && (o_mode == m1) && (m1 == m2);
  reg_write_a: assert property (i_misc_wr |=> o_misc_control_reg == $past(i_misc_wdata))
    else $error("control register missed a write");
  mode_map_a: assert property ((up != 3'h0) |-> o_mode ==
    {$past(o_misc_control_reg[3]), ^$past(o_misc_control_reg[4:3])}) else $error("mode wrong");
  loop_path_a: assert property (st && o_mode == sdle_pkg::SDLE_LOOP |->
    o_rx_serial == $past(i_tx_serial) && o_tx_data_pin == $past(i_tx_serial))
    else $error("loopback path wrong");
  echo_path_a: assert property (st && o_mode[1] |-> o_tx_data_pin == $past(i_rx_data_pin, 3)
    && o_rx_serial == $past(i_rx_data_pin, 3)) else $error("echo path wrong");
  norm_path_a: assert property (st && o_mode == sdle_pkg::SDLE_NORMAL |->
    o_tx_data_pin == $past(i_tx_serial) && o_rx_serial == $past(i_rx_data_pin, 3))
    else $error("normal path wrong");
  recov_src_a: assert property (up == 3'h7 |-> o_recov_data == $past(i_rx_data_pin, 3))
    else $error("recovery data not from receive pin");
  recov_clk_a: assert property (up == 3'h7 |-> o_recov_clock == $past(i_rx_tx_clock_pin, 3))
    else $error("recovery clock not from clock pin");
  loop_enab_a: assert property (st && !o_mode[1] && o_mode[0] || st && o_mode == 2'h2 |->
    o_tx_enable == $past(i_tx_enable_sw) && o_rx_enable == $past(i_rx_enable_sw))
    else $error("modem pins not ignored");
  echo_cts_a: assert property (st && o_mode == sdle_pkg::SDLE_ECHO |->
    o_tx_enable == $past(i_tx_enable_sw)) else $error("clear to send not ignored in echo");
  cover property (st && o_mode == sdle_pkg::SDLE_LOOP);
  cover property (st && o_mode == sdle_pkg::SDLE_ECHO);
  cover property (st && o_mode == sdle_pkg::SDLE_BOTH);
endmodule : sdle_switch_chk

bind sdle_switch sdle_switch_chk u_sdle_switch_chk (.*);

// >>> test/sdle_line_model.sv
// partner: serial station sending on the receive pin and listening to the transmit pin
module sdle_line_model (
  input  wire logic        i_tx_pin,
  input  wire logic        i_go,
  input  wire logic [15:0] i_word,
  output      logic        o_rx_pin,
  output      logic        o_clk,
  output      logic        o_busy,
  output      logic [15:0] o_seen
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // free running recovery clock and bit framing
  // ****************************************************************
  // the peripheral clock stays at 16 MHz elsewhere; this block never sees it
  localparam int unsigned OVS = 16;
  initial begin
    o_clk = 1'b0;
    // phase offset keeps clock pin and line edges off the system clock edges
    #0.3;
    forever #15.625 o_clk = ~o_clk;
  end
  initial begin
    o_rx_pin = 1'b1;
    o_busy = 1'b0;
    o_seen = 16'h0000;
    forever begin
      @(posedge i_go);
      o_busy = 1'b1;
      for (int b = 15; b >= 0; b--) begin
        o_rx_pin = i_word[b];
        repeat (OVS / 2) @(posedge o_clk);
        o_seen = {o_seen[14:0], i_tx_pin};
        repeat (OVS / 2) @(posedge o_clk);
      end
      // idle line rests at mark
      o_rx_pin = 1'b1;
      o_busy = 1'b0;
    end
  end
endmodule : sdle_line_model

// >>> test/serial_diag_loopback_echo_tb_top.sv
// testbench: scenario tasks for the loopback and auto echo switch
module serial_diag_loopback_echo_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst_b, wr, auto_en, cd_b, cts_b, tx_ser, tx_sw, rx_sw, go;
  logic [7:0]  wdata, reg_q;
  logic [1:0]  mode;
  logic        rx_pin, lclk, busy, tx_pin, tx_en, rx_ser, rx_en, rec_d, rec_c;
  logic [15:0] seen, word;
  int          mismatches = 0;
  int          n_compared = 0;
  sdle_switch u_sdle_switch (.i_clk_sys(clk), .i_rst_b(rst_b), .i_misc_wr(wr),
    .i_misc_wdata(wdata), .i_auto_enables(auto_en), .i_rx_data_pin(rx_pin),
    .i_carrier_detect_in_b(cd_b), .i_clear_to_send_in_b(cts_b), .i_rx_tx_clock_pin(lclk),
    .o_tx_data_pin(tx_pin), .i_tx_serial(tx_ser), .i_tx_enable_sw(tx_sw), .o_tx_enable(tx_en),
    .i_rx_enable_sw(rx_sw), .o_rx_serial(rx_ser), .o_rx_enable(rx_en), .o_recov_data(rec_d),
    .o_recov_clock(rec_c), .o_misc_control_reg(reg_q), .o_mode(mode));
  sdle_line_model u_sdle_line_model (.i_tx_pin(tx_pin), .i_go(go), .i_word(word),
    .o_rx_pin(rx_pin), .o_clk(lclk), .o_busy(busy), .o_seen(seen));
  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] d);
    @(negedge clk);
    wr = 1'b1;
    wdata = d;
    @(negedge clk);
    wr = 1'b0;
    repeat (4) @(negedge clk);
  endtask : wr_reg
  task automatic conclude;
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_modes;
    logic [7:0] d;
    for (int i = 0; i < 4; i++) begin
      // unused bits ride along to show they are stored
      d = 8'(i << 3) ^ 8'h45;
      wr_reg(d);
      chk(16'({mode, reg_q}), 16'({d[3], d[4] ^ d[3], d}));
    end
  endtask : t_modes
  task automatic t_norm;
    wr_reg(8'h00);
    {auto_en, tx_sw, rx_sw, cts_b, cd_b, tx_ser} = 6'h3e;
    repeat (5) @(negedge clk);
    chk(16'({tx_en, rx_en, tx_pin, rx_ser}), 16'h0001);
    {cts_b, cd_b} = 2'h0;
    repeat (5) @(negedge clk);
    chk(16'({tx_en, rx_en, tx_pin, rx_ser}), 16'h000d);
  endtask : t_norm
  task automatic t_loop;
    // modem inputs go inactive first, so enables found up once loopback is set prove they are ignored
    {cts_b, cd_b} = 2'h3;
    wr_reg(8'h10);
    for (int i = 0; i < 4; i++) begin
      tx_ser = i[0];
      @(negedge clk);
      chk(16'({tx_pin, rx_ser, tx_en, rx_en, rec_d}), 16'({i[0], i[0], 3'h7}));
    end
  endtask : t_loop
  task automatic t_echo;
    wr_reg(8'h08);
    {cts_b, cd_b} = 2'h2;
    word = 16'hc5a3;
    go = 1'b1;
    @(negedge clk);
    go = 1'b0;
    for (int i = 0; i < 3000 && busy !== 1'b0; i++) @(negedge clk);
    chk(seen, word);
    chk(16'({tx_en, rx_en}), 16'h0003);
  endtask : t_echo
  task automatic t_both;
    {cts_b, cd_b} = 2'h3;
    tx_ser = 1'b0;
    wr_reg(8'h18);
    repeat (2) @(negedge clk);
    chk(16'({tx_en, rx_en, tx_pin}), 16'h0007);
  endtask : t_both
  task automatic t_reset;
    rst_b = 1'b0;
    repeat (3) @(negedge clk);
    chk(16'({tx_pin, tx_en, rx_ser, rx_en, rec_d, rec_c, mode, reg_q}), 16'ha800);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    chk(16'({mode, reg_q}), 16'({2'h0, sdle_pkg::MISC_RESET_VAL}));
  endtask : t_reset
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    // long enough for one echoed word plus the short scenarios
    #50us;
    mismatches++;
    conclude();
  end
  initial begin
    {rst_b, wr, auto_en, tx_ser, tx_sw, rx_sw, go} = 7'h00;
    {cd_b, cts_b} = 2'h3;
    wdata = 8'h00;
    word = 16'h0000;
    repeat (19) @(negedge clk);
    chk(16'({tx_pin, tx_en, rx_ser, rx_en, rec_d, rec_c, mode, reg_q}), 16'ha800);
    @(negedge clk);
    rst_b = 1'b1;
    t_modes();
    t_norm();
    t_loop();
    t_echo();
    t_both();
    t_reset();
    conclude();
  end
endmodule : serial_diag_loopback_echo_tb_top
